// *** design/csb_regs.svh ***
// Constants of the store, stack, bit and flag execution unit.
// Assumes inclusion by bare name from the unit and the bench; holds definitions only.
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH

// Bit positions inside the flags register.
`define CSB_FLAG_C 3'h0
`define CSB_FLAG_Z 3'h1
`define CSB_FLAG_N 3'h2
`define CSB_FLAG_V 3'h3
`define CSB_FLAG_S 3'h4
`define CSB_FLAG_H 3'h5
`define CSB_FLAG_T 3'h6
`define CSB_FLAG_I 3'h7

// Low byte of each pointer pair inside the register file.
`define CSB_IDX_X 5'h1A
`define CSB_IDX_Y 5'h1C
`define CSB_IDX_Z 5'h1E

// Offsets on the software register port; 6'h00 to 6'h1F reach the register file.
`define CSB_OFS_FLAGS 6'h20
`define CSB_OFS_SP_LO 6'h21
`define CSB_OFS_SP_HI 6'h22
`define CSB_OFS_STATUS 6'h23
`define CSB_STATUS_BUSY 3'h0

// Reset values.
`define CSB_FLAGS_RST 8'h00
`define CSB_SP_RST 16'h0000
`define CSB_RF_RST 8'h00

// Cycles taken by each instruction group.
`define CSB_CYC_ONE 2'h1
`define CSB_CYC_TWO 2'h2
`define CSB_CYC_LPM 2'h3

`endif

// *** design/csb_pkg.sv ***
// Types shared by the store, stack, bit and flag execution unit and its bench.
// Assumes the decoder upstream fills every field of an instruction word.
package csb_pkg;

  // Operations executed by the unit.
  typedef enum logic [4:0] {
    OP_NOP, OP_MEM_WRITE_INDIRECT, OP_DIRECT_MEM_WRITE, OP_PROGRAM_MEMORY_READ,
    OP_PUSH, OP_POP, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_LEFT_ROTATE_CARRY,
    OP_RIGHT_ROTATE_CARRY, OP_ARITH_RIGHT_SHIFT,
    OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
    OP_GENERIC_FLAG_ON, OP_GENERIC_FLAG_OFF
  } csb_op_t;

  // Pointer pair used by indirect forms.
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} csb_ptr_t;

  // Address mode of indirect forms.
  typedef enum logic [1:0] {AM_PLAIN, AM_POST_INC, AM_PRE_DEC, AM_DISP} csb_amode_t;

  // One decoded instruction.
  typedef struct packed {
    csb_op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bidx;
    csb_ptr_t ptr;
    csb_amode_t amode;
    logic [5:0] disp;
    logic [4:0] io_addr;
    logic [15:0] k;
  } csb_instr_t;

  // Data memory request.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } csb_dm_req_t;

  // Program memory request.
  typedef struct packed {
    logic [15:0] addr;
    logic re;
  } csb_pm_req_t;

  // I/O space request with a per-bit write mask.
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic we;
  } csb_io_req_t;

  // Unit states.
  typedef enum logic {ST_IDLE, ST_BUSY} csb_state_t;

endpackage : csb_pkg

// *** design/csb_exec.sv ***
// Execution unit for stores, program memory reads, stack, I/O bit, shift and flag ops.
// Assumes synchronous memories that return read data in the cycle after the request,
// an I/O space that honours a per-bit write mask, and a decoder that waits on ready.
//
// Function
// - Pre-decrement pointer, then store; two cycles.
// - Store, then post-increment X, Y or Z; two cycles.
// - Store at pointer plus displacement; pointer kept.
// - Direct store at absolute address; two cycles.
// - Program byte by Z; optional increment; three cycles.
// - Push writes register to stack; two cycles.
// - Pop reads stack byte to register; two cycles.
// - Set one I/O bit, others kept.
// - Clear one I/O bit, others kept.
// - Left shift or rotate; update Z C N V.
// - Right shifts and rotate; update Z C N V.
// - Copy register bit into transfer flag.
// - Copy transfer flag into register bit.
// - Set or clear one flag, nothing else.
// - Overflow and signed flags set individually.
`timescale 1ns/100ps
`include "csb_regs.svh"

module csb_exec (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic ins_valid, // Decoded instruction offered.
  input wire csb_pkg::csb_instr_t ins, // Decoded instruction.
  output logic ins_ready, // Unit can take an instruction.
  output csb_pkg::csb_dm_req_t dm, // Data memory request.
  input wire logic [7:0] dm_rdata, // Data memory read data.
  output csb_pkg::csb_pm_req_t pm, // Program memory request.
  input wire logic [7:0] pm_rdata, // Program memory read data.
  output csb_pkg::csb_io_req_t io, // I/O space request.
  input wire logic [5:0] sw_addr, // Register port address.
  input wire logic [7:0] sw_wdata, // Register port write data.
  input wire logic sw_we, // Register port write strobe.
  input wire logic sw_re, // Register port read strobe.
  output logic [7:0] sw_rdata, // Register port read data.
  output logic [7:0] flags // Flags register contents.
);

  csb_pkg::csb_state_t state_q;
  csb_pkg::csb_state_t state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  csb_pkg::csb_op_t op_q;
  logic [4:0] rd_q;
  logic ins_ready_q;
  logic [7:0] rf_q [32];
  logic [7:0] rf_d [32];
  logic [7:0] rf_eff [32];
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [15:0] sp_q;
  logic [15:0] sp_d;
  logic wb_pend_q;
  logic [4:0] wb_idx_q;
  csb_pkg::csb_dm_req_t dm_q;
  csb_pkg::csb_dm_req_t dm_d;
  csb_pkg::csb_pm_req_t pm_q;
  csb_pkg::csb_pm_req_t pm_d;
  csb_pkg::csb_io_req_t io_q;
  csb_pkg::csb_io_req_t io_d;
  logic [7:0] sw_rdata_q;
  logic [7:0] sw_rdata_d;
  logic [1:0] cyc_ld;
  logic [7:0] sh_res;
  logic sh_c;

  // Operation decode. The offered word is looked at every cycle,
  // but nothing moves unless accept is high.
  wire busy = (state_q == csb_pkg::ST_BUSY);
  wire accept = ins_valid && ins_ready_q;
  wire is_st = (ins.op == csb_pkg::OP_MEM_WRITE_INDIRECT);
  wire is_sts = (ins.op == csb_pkg::OP_DIRECT_MEM_WRITE);
  wire is_lpm = (ins.op == csb_pkg::OP_PROGRAM_MEMORY_READ);
  wire is_push = (ins.op == csb_pkg::OP_PUSH);
  wire is_pop = (ins.op == csb_pkg::OP_POP);
  wire is_sbi = (ins.op == csb_pkg::OP_IO_BIT_SET);
  wire is_cbi = (ins.op == csb_pkg::OP_IO_BIT_CLEAR);
  wire is_bst = (ins.op == csb_pkg::OP_BIT_TO_TRANSFER_FLAG);
  wire is_bld = (ins.op == csb_pkg::OP_TRANSFER_FLAG_TO_BIT);
  wire is_fon = (ins.op == csb_pkg::OP_GENERIC_FLAG_ON);
  wire is_foff = (ins.op == csb_pkg::OP_GENERIC_FLAG_OFF);
  wire is_shift = (ins.op == csb_pkg::OP_LOGICAL_LEFT_SHIFT)
    || (ins.op == csb_pkg::OP_LOGICAL_RIGHT_SHIFT)
    || (ins.op == csb_pkg::OP_LEFT_ROTATE_CARRY)
    || (ins.op == csb_pkg::OP_RIGHT_ROTATE_CARRY)
    || (ins.op == csb_pkg::OP_ARITH_RIGHT_SHIFT);
  wire [7:0] bit_mask = 8'h01 << ins.bidx;

  // A popped byte lands one edge after the unit frees up, so every operand read
  // sees it through this bypass; a back-to-back user of the register is never stale.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_rf
      assign rf_eff[gi] = (wb_pend_q && wb_idx_q == 5'(gi)) ? dm_rdata : rf_q[gi];
    end
  endgenerate

  // Operands and pointer arithmetic.
  wire [7:0] rr_val = rf_eff[ins.rr];
  wire [7:0] rd_val = rf_eff[ins.rd];
  wire [4:0] p_sel = (ins.ptr == csb_pkg::PTR_X) ? `CSB_IDX_X :
    (ins.ptr == csb_pkg::PTR_Y) ? `CSB_IDX_Y : `CSB_IDX_Z;
  wire [4:0] p_idx = is_lpm ? `CSB_IDX_Z : p_sel;
  wire [4:0] p_idx_hi = 5'(p_idx + 5'h01);
  wire [15:0] ptr_val = {rf_eff[p_idx_hi], rf_eff[p_idx]};
  wire [15:0] ptr_inc = 16'(ptr_val + 16'h0001);
  wire [15:0] ptr_dec = 16'(ptr_val - 16'h0001);
  wire [15:0] ptr_disp = 16'(ptr_val + {10'h000, ins.disp});
  wire am_pre = (ins.amode == csb_pkg::AM_PRE_DEC);
  wire am_post = (ins.amode == csb_pkg::AM_POST_INC);
  wire am_disp = (ins.amode == csb_pkg::AM_DISP);

  // Store address: decremented pointer first, displaced pointer, or pointer as is.
  // The displacement is unsigned, so a displaced store lands below the pointer only when the 16-bit sum wraps past FFFF.
  wire [15:0] st_addr = am_pre ? ptr_dec : am_disp ? ptr_disp : ptr_val;

  // Pointer write-back; a displaced or plain form leaves the pair alone.
  // Both halves of the pair change at the same edge, so software never sees half a step.
  wire p_wen = accept && ((is_st && (am_pre || am_post)) || (is_lpm && am_post));
  wire [15:0] p_new = am_pre ? ptr_dec : ptr_inc;

  // Shift and rotate data path; carry in only for the rotates.
  // Arithmetic right shift keeps bit 7, so a signed value halves with its sign.
  always_comb begin
    sh_res = rd_val;
    sh_c = flags_q[`CSB_FLAG_C];
    case (ins.op)
      csb_pkg::OP_LOGICAL_LEFT_SHIFT: begin
        sh_res = {rd_val[6:0], 1'b0};
        sh_c = rd_val[7];
      end
      csb_pkg::OP_LEFT_ROTATE_CARRY: begin
        sh_res = {rd_val[6:0], flags_q[`CSB_FLAG_C]};
        sh_c = rd_val[7];
      end
      csb_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
        sh_res = {1'b0, rd_val[7:1]};
        sh_c = rd_val[0];
      end
      csb_pkg::OP_RIGHT_ROTATE_CARRY: begin
        sh_res = {flags_q[`CSB_FLAG_C], rd_val[7:1]};
        sh_c = rd_val[0];
      end
      csb_pkg::OP_ARITH_RIGHT_SHIFT: begin
        sh_res = {rd_val[7], rd_val[7:1]};
        sh_c = rd_val[0];
      end
      default: begin
        sh_res = rd_val;
        sh_c = flags_q[`CSB_FLAG_C];
      end
    endcase
  end

  // Register file result port: program byte write-back, shift result or bit load.
  wire lpm_wb = busy && (op_q == csb_pkg::OP_PROGRAM_MEMORY_READ) && (cnt_q == 2'h1);
  wire res_en = lpm_wb || (accept && (is_shift || is_bld));
  wire [4:0] res_idx = lpm_wb ? rd_q : ins.rd;
  wire [7:0] bld_val = (rd_val & ~bit_mask) | (flags_q[`CSB_FLAG_T] ? bit_mask : 8'h00);
  wire [7:0] res_val = lpm_wb ? pm_rdata : is_bld ? bld_val : sh_res;

  // Register file next values; instruction writes win over a software write.
  // A landing pop byte counts as an instruction write, so a software write to
  // the same register in that cycle cannot hide it.
  generate
    for (gi = 0; gi < 32; gi++) begin : g_rf_d
      assign rf_d[gi] = (res_en && res_idx == 5'(gi)) ? res_val :
        (p_wen && p_idx == 5'(gi)) ? p_new[7:0] :
        (p_wen && p_idx_hi == 5'(gi)) ? p_new[15:8] :
        (wb_pend_q && wb_idx_q == 5'(gi)) ? dm_rdata :
        (sw_we && sw_addr == 6'(gi)) ? sw_wdata : rf_eff[gi];
    end
  endgenerate

  // Shift flag update: only Z, C, N and V move; V is N exclusive-or C.
  // S and H keep their value here; only the flag instructions and a register port write to the flags move them.
  wire [7:0] sh_flags = {flags_q[7:4], sh_res[7] ^ sh_c, sh_res[7], sh_res == 8'h00, sh_c};

  // Flags next value; each flag instruction touches the one bit it names.
  // A software write to the flags loses to a shift, bit-to-flag or flag instruction in the same cycle.
  wire [7:0] t_mask = 8'h01 << `CSB_FLAG_T;
  wire [7:0] bst_flags = (flags_q & ~t_mask) | (rr_val[ins.bidx] ? t_mask : 8'h00);
  assign flags_d = (accept && is_shift) ? sh_flags :
    (accept && is_bst) ? bst_flags :
    (accept && is_fon) ? (flags_q | bit_mask) :
    (accept && is_foff) ? (flags_q & ~bit_mask) :
    (sw_we && sw_addr == `CSB_OFS_FLAGS) ? sw_wdata : flags_q;

  // Stack pointer: push writes then decrements, pop increments then reads.
  // The pointer thus always names the next free byte.
  wire [15:0] sp_inc = 16'(sp_q + 16'h0001);
  wire [15:0] sp_dec = 16'(sp_q - 16'h0001);
  assign sp_d = (accept && is_push) ? sp_dec :
    (accept && is_pop) ? sp_inc :
    (sw_we && sw_addr == `CSB_OFS_SP_LO) ? {sp_q[15:8], sw_wdata} :
    (sw_we && sw_addr == `CSB_OFS_SP_HI) ? {sw_wdata, sp_q[7:0]} : sp_q;

  // Data memory request; strobes last exactly one cycle after acceptance.
  // Address and data are held after the strobe, which keeps the lines quiet.
  wire dm_wr = accept && (is_st || is_sts || is_push);
  wire [15:0] dm_wr_addr = is_st ? st_addr : is_sts ? ins.k : sp_q;
  assign dm_d.addr = dm_wr ? dm_wr_addr : (accept && is_pop) ? sp_inc : dm_q.addr;
  assign dm_d.wdata = dm_wr ? rr_val : dm_q.wdata;
  assign dm_d.we = dm_wr;
  assign dm_d.re = accept && is_pop;

  // Program memory request, addressed by Z before any increment.
  // A plain read relies on the decoder giving register zero as the target.
  assign pm_d.addr = (accept && is_lpm) ? ptr_val : pm_q.addr;
  assign pm_d.re = accept && is_lpm;

  // I/O bit writes go out masked, so the far side never sees a read-modify-write
  // and the neighbouring bits cannot be disturbed by a stale copy.
  wire io_wr = accept && (is_sbi || is_cbi);
  assign io_d.addr = io_wr ? ins.io_addr : io_q.addr;
  assign io_d.wmask = io_wr ? bit_mask : io_q.wmask;
  assign io_d.wdata = io_wr ? (is_sbi ? 8'hFF : 8'h00) : io_q.wdata;
  assign io_d.we = io_wr;

  // Cycle count per operation.
  always_comb begin
    case (ins.op)
      csb_pkg::OP_MEM_WRITE_INDIRECT: cyc_ld = `CSB_CYC_TWO;
      csb_pkg::OP_DIRECT_MEM_WRITE: cyc_ld = `CSB_CYC_TWO;
      csb_pkg::OP_PROGRAM_MEMORY_READ: cyc_ld = `CSB_CYC_LPM;
      csb_pkg::OP_PUSH: cyc_ld = `CSB_CYC_TWO;
      csb_pkg::OP_POP: cyc_ld = `CSB_CYC_TWO;
      csb_pkg::OP_IO_BIT_SET: cyc_ld = `CSB_CYC_TWO;
      csb_pkg::OP_IO_BIT_CLEAR: cyc_ld = `CSB_CYC_TWO;
      default: cyc_ld = `CSB_CYC_ONE;
    endcase
  end

  // Sequencer: ready stays low for the extra cycles, so nothing can cut in
  // between the memory access and the pointer or stack update.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      csb_pkg::ST_IDLE: begin
        if (accept && cyc_ld != `CSB_CYC_ONE) begin
          state_d = csb_pkg::ST_BUSY;
          cnt_d = 2'(cyc_ld - 2'h1);
        end
      end
      csb_pkg::ST_BUSY: begin
        cnt_d = 2'(cnt_q - 2'h1);
        if (cnt_q == 2'h1) begin
          state_d = csb_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = csb_pkg::ST_IDLE;
        cnt_d = 2'h0;
      end
    endcase
  end

  // Register port read mux; unmapped offsets read as zero.
  wire [7:0] status_val = {7'h00, state_d == csb_pkg::ST_BUSY};
  assign sw_rdata_d = !sw_re ? sw_rdata_q :
    !sw_addr[5] ? rf_eff[sw_addr[4:0]] :
    (sw_addr == `CSB_OFS_FLAGS) ? flags_q :
    (sw_addr == `CSB_OFS_SP_LO) ? sp_q[7:0] :
    (sw_addr == `CSB_OFS_SP_HI) ? sp_q[15:8] :
    (sw_addr == `CSB_OFS_STATUS) ? status_val : 8'h00;

  // Sequencer and operation latch.
  // Ready follows the next state, so it drops in the first cycle of a long op.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= csb_pkg::ST_IDLE;
      cnt_q <= 2'h0;
      op_q <= csb_pkg::OP_NOP;
      rd_q <= 5'h00;
      ins_ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      op_q <= accept ? ins.op : op_q;
      rd_q <= accept ? ins.rd : rd_q;
      ins_ready_q <= (state_d == csb_pkg::ST_IDLE);
    end
  end

  // Pop write-back is armed in the last busy cycle and lands one edge later.
  // The index is latched every cycle; only the pending flag gives it effect.
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_pend_q <= 1'b0;
      wb_idx_q <= 5'h00;
    end else begin
      wb_pend_q <= busy && (op_q == csb_pkg::OP_POP) && (cnt_q == 2'h1);
      wb_idx_q <= rd_q;
    end
  end

  // Architectural state.
  // All registers clear in reset, so every pointer starts at address zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      rf_q <= '{default: `CSB_RF_RST};
      flags_q <= `CSB_FLAGS_RST;
      sp_q <= `CSB_SP_RST;
    end else begin
      rf_q <= rf_d;
      flags_q <= flags_d;
      sp_q <= sp_d;
    end
  end

  // Request and read data registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      dm_q <= '0;
      pm_q <= '0;
      io_q <= '0;
      sw_rdata_q <= 8'h00;
    end else begin
      dm_q <= dm_d;
      pm_q <= pm_d;
      io_q <= io_d;
      sw_rdata_q <= sw_rdata_d;
    end
  end

  // Outputs straight from flip-flops.
  // Registered outputs cost a cycle of latency but keep the far side's timing clean.
  assign ins_ready = ins_ready_q;
  assign dm = dm_q;
  assign pm = pm_q;
  assign io = io_q;
  assign sw_rdata = sw_rdata_q;
  assign flags = flags_q;

endmodule : csb_exec

// *** verif/csb_mem_model.sv ***
// Data memory, program memory and I/O space facing the execution unit.
// Assumes the unit's registered one-cycle strobes on the one system clock.
`timescale 1ns/100ps

module csb_mem_model (
  input wire logic clk, // System clock.
  input wire csb_pkg::csb_dm_req_t dm, // Data memory request.
  output logic [7:0] dm_rdata, // Data memory read data.
  input wire csb_pkg::csb_pm_req_t pm, // Program memory request.
  output logic [7:0] pm_rdata, // Program memory read data.
  input wire csb_pkg::csb_io_req_t io // I/O write request.
);
  logic [7:0] dmem [0:65535];
  logic [7:0] pmem [0:65535];
  logic [7:0] iomem [0:31];
  logic [7:0] dm_q = 8'h5A;
  logic [7:0] pm_q = 8'hA5;

  // Read lines start from a known pattern and have one process driving them.
  assign dm_rdata = dm_q;
  assign pm_rdata = pm_q;

  // Reads answer one cycle late; between answers the lines flip so stale data never pass.
  always @(posedge clk) begin
    dm_q <= dm.re ? dmem[dm.addr] : ~dm_q;
    pm_q <= pm.re ? pmem[pm.addr] : ~pm_q;
    if (dm.we) begin
      dmem[dm.addr] <= dm.wdata;
    end
    if (io.we) begin
      iomem[io.addr] <= (iomem[io.addr] & ~io.wmask) | (io.wdata & io.wmask);
    end
  end
endmodule : csb_mem_model

// *** verif/csb_exec_props.sv ***
// Port checks of the store, stack, bit and flag execution unit.
// Assumes binding to csb_exec; one clock, synchronous reset.
`timescale 1ns/100ps

module csb_exec_props (
  input wire logic clk, // System clock.
  input wire logic reset, // Synchronous reset.
  input wire logic ins_valid, // Instruction offered.
  input wire csb_pkg::csb_instr_t ins, // Decoded instruction.
  input wire logic ins_ready, // Unit can take one.
  input wire csb_pkg::csb_dm_req_t dm, // Data memory request.
  input wire csb_pkg::csb_pm_req_t pm, // Program memory request.
  input wire csb_pkg::csb_io_req_t io, // I/O request.
  input wire logic [7:0] flags // Flags register.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Accepted operations, one wire each.
  wire logic take = ins_valid && ins_ready;
  wire logic t_dir = take && ins.op == csb_pkg::OP_DIRECT_MEM_WRITE;
  wire logic t_pop = take && ins.op == csb_pkg::OP_POP;
  wire logic t_lpm = take && ins.op == csb_pkg::OP_PROGRAM_MEMORY_READ;
  wire logic t_sbi = take && ins.op == csb_pkg::OP_IO_BIT_SET;
  wire logic t_cbi = take && ins.op == csb_pkg::OP_IO_BIT_CLEAR;
  wire logic t_fon = take && ins.op == csb_pkg::OP_GENERIC_FLAG_ON;
  wire logic t_sh = take && ins.op inside {[csb_pkg::OP_LOGICAL_LEFT_SHIFT:
    csb_pkg::OP_ARITH_RIGHT_SHIFT]};

  property p_dir;
    t_dir |=> dm.we && dm.addr == $past(ins.k) && !ins_ready ##1 ins_ready && $stable(flags);
  endproperty
  a_dir: assert property (p_dir) else $error("direct store wrong");
  property p_pop;
    t_pop |=> dm.re && !dm.we && !ins_ready ##1 ins_ready && !dm.re;
  endproperty
  a_pop: assert property (p_pop) else $error("pop timing wrong");
  property p_lpm;
    t_lpm |=> pm.re && !ins_ready ##1 !pm.re && !ins_ready ##1 ins_ready;
  endproperty
  a_lpm: assert property (p_lpm) else $error("program read timing wrong");
  property p_sbi;
    t_sbi |=> io.we && io.addr == $past(ins.io_addr) && io.wmask == 8'h01 << $past(ins.bidx)
      && (io.wdata & io.wmask) == io.wmask;
  endproperty
  a_sbi: assert property (p_sbi) else $error("bit set write wrong");
  property p_cbi;
    t_cbi |=> io.we && io.wmask == 8'h01 << $past(ins.bidx) && (io.wdata & io.wmask) == 8'h00
      ##1 ins_ready;
  endproperty
  a_cbi: assert property (p_cbi) else $error("bit clear write wrong");
  property p_sh;
    t_sh |=> flags[3] == (flags[2] ^ flags[0]) && flags[7:4] == $past(flags[7:4]) && ins_ready;
  endproperty
  a_sh: assert property (p_sh) else $error("shift flags wrong");
  property p_fon;
    t_fon |=> flags == ($past(flags) | 8'h01 << $past(ins.bidx));
  endproperty
  a_fon: assert property (p_fon) else $error("flag set wrong");
  property p_atom;
    dm.we || dm.re || io.we || pm.re |-> !ins_ready;
  endproperty
  a_atom: assert property (p_atom) else $error("accepting during access");

  c_lpm: cover property (t_lpm);
  c_pop: cover property (t_pop);
  c_sbi: cover property (t_sbi);
endmodule : csb_exec_props

bind csb_exec csb_exec_props i_csb_exec_props (.clk(clk), .reset(reset),
  .ins_valid(ins_valid), .ins(ins), .ins_ready(ins_ready), .dm(dm), .pm(pm), .io(io),
  .flags(flags));

// *** verif/tb_cpu_store_bit_flag_ops.sv ***
// Self-checking bench for the store, stack, bit and flag execution unit.
// Assumes csb_mem_model on the far side and the bound port checker.
`timescale 1ns/100ps
`include "csb_regs.svh"

module tb_cpu_store_bit_flag_ops;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ins_valid = 1'b0;
  logic sw_we = 1'b0;
  logic sw_re = 1'b0;
  logic [5:0] sw_addr = 6'h00;
  logic [7:0] sw_wdata = 8'h00;
  csb_pkg::csb_instr_t ins = '0;
  csb_pkg::csb_dm_req_t dm;
  csb_pkg::csb_pm_req_t pm;
  csb_pkg::csb_io_req_t io;
  logic ins_ready;
  logic [7:0] dm_rdata, pm_rdata, sw_rdata, flags;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  // A 10 MHz clock.
  always #50 clk = ~clk;

  csb_exec i_csb_exec (.clk(clk), .reset(reset), .ins_valid(ins_valid), .ins(ins),
    .ins_ready(ins_ready), .dm(dm), .dm_rdata(dm_rdata), .pm(pm), .pm_rdata(pm_rdata),
    .io(io), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re),
    .sw_rdata(sw_rdata), .flags(flags));
  csb_mem_model i_csb_mem_model (.clk(clk), .dm(dm), .dm_rdata(dm_rdata), .pm(pm),
    .pm_rdata(pm_rdata), .io(io));

  // The tests need under 3000 cycles, so a hang is cut at 6000.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Register port cycles; every task starts and ends at a rising edge.
  task automatic sw_wr(input logic [5:0] a, input logic [7:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_we <= 1'b1;
    @(posedge clk);
    sw_we <= 1'b0;
    @(posedge clk);
  endtask : sw_wr

  task automatic sw_rd(input logic [5:0] a, output logic [7:0] d);
    sw_addr <= a;
    sw_re <= 1'b1;
    @(posedge clk);
    sw_re <= 1'b0;
    @(posedge clk);
    d = sw_rdata;
  endtask : sw_rd

  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    sw_wr(a, v[7:0]);
    sw_wr(a + 6'h01, v[15:8]);
  endtask : wr16

  task automatic rd16(input logic [5:0] a, output logic [15:0] v);
    sw_rd(a, v[7:0]);
    sw_rd(a + 6'h01, v[15:8]);
  endtask : rd16

  // One offer, taken at once; the wait covers the longest op and its write-back.
  task automatic exec(input csb_pkg::csb_instr_t i);
    ins <= i;
    ins_valid <= 1'b1;
    @(posedge clk);
    ins_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : exec

  function automatic csb_pkg::csb_instr_t mk(csb_pkg::csb_op_t op, logic [4:0] rd,
      logic [4:0] rr, logic [2:0] b);
    mk = '0;
    mk.op = op;
    mk.rd = rd;
    mk.rr = rr;
    mk.bidx = b;
  endfunction : mk

  // Reference shift and rotate: returns flags and value.
  function automatic logic [15:0] shref(csb_pkg::csb_op_t op, logic [7:0] v, logic [7:0] f);
    logic [7:0] r;
    logic c;
    case (op)
      csb_pkg::OP_LOGICAL_LEFT_SHIFT: {c, r} = {v, 1'b0};
      csb_pkg::OP_LEFT_ROTATE_CARRY: {c, r} = {v, f[`CSB_FLAG_C]};
      csb_pkg::OP_LOGICAL_RIGHT_SHIFT: {r, c} = {1'b0, v};
      csb_pkg::OP_RIGHT_ROTATE_CARRY: {r, c} = {f[`CSB_FLAG_C], v};
      default: {r, c} = {v[7], v};
    endcase
    f[`CSB_FLAG_C] = c;
    f[`CSB_FLAG_Z] = (r == 8'h00);
    f[`CSB_FLAG_N] = r[7];
    f[`CSB_FLAG_V] = r[7] ^ c;
    return {f, r};
  endfunction : shref

  // Main sequence.
  initial begin
    csb_pkg::csb_instr_t t;
    logic [15:0] b, v, ea;
    logic [7:0] d, f, r, w;
    logic [5:0] q, a;
    int stk[$];
    void'($urandom(4956));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    sw_wr(6'h3F, 8'h5A);
    sw_rd(6'h3F, r);
    check("unmapped read", r, 8'h00);
    sw_rd(`CSB_OFS_FLAGS, r);
    check("flags after reset", r, `CSB_FLAGS_RST);
    sw_rd(`CSB_OFS_STATUS, r);
    check("idle status", r, 8'h00);
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 4; m++) begin
        b = 16'h0100 + 16'($urandom_range(0, 255));
        d = 8'($urandom);
        q = 6'($urandom);
        a = 6'(`CSB_IDX_X + 5'(2 * p));
        t = mk(csb_pkg::OP_MEM_WRITE_INDIRECT, 5'h00, 5'h03, 3'h0);
        t.ptr = csb_pkg::csb_ptr_t'(p);
        t.amode = csb_pkg::csb_amode_t'(m);
        t.disp = q;
        wr16(a, b);
        sw_wr(6'h03, d);
        exec(t);
        ea = (m == 2) ? b - 16'h0001 : (m == 3) ? b + 16'(q) : b;
        check("stored byte", i_csb_mem_model.dmem[ea], d);
        rd16(a, v);
        check("pointer", v, (m == 1) ? b + 16'h0001 : (m == 2) ? ea : b);
      end
    end
    b = 16'h0300 + 16'($urandom_range(0, 255));
    sw_wr(6'h09, d);
    t = mk(csb_pkg::OP_DIRECT_MEM_WRITE, 5'h00, 5'h09, 3'h0);
    t.k = b;
    exec(t);
    check("direct byte", i_csb_mem_model.dmem[b], d);
    wr16(`CSB_OFS_SP_LO, 16'h0200);
    exec(mk(csb_pkg::OP_PUSH, 5'h00, 5'h09, 3'h0));
    stk.push_back(int'(d));
    check("pushed byte", i_csb_mem_model.dmem[16'h0200], d);
    rd16(`CSB_OFS_SP_LO, v);
    check("stack pointer after push", v, 16'h01FF);
    exec(mk(csb_pkg::OP_POP, 5'h04, 5'h00, 3'h0));
    sw_rd(6'h04, r);
    check("popped byte", r, 16'(stk.pop_back()));
    rd16(`CSB_OFS_SP_LO, v);
    check("stack pointer after pop", v, 16'h0200);
    $display("store and stack test done");
    for (int m = 0; m < 2; m++) begin
      b = 16'($urandom);
      d = 8'($urandom);
      i_csb_mem_model.pmem[b] = d;
      wr16({1'b0, `CSB_IDX_Z}, b);
      t = mk(csb_pkg::OP_PROGRAM_MEMORY_READ, 5'(7 * m), 5'h00, 3'h0);
      t.amode = m ? csb_pkg::AM_POST_INC : csb_pkg::AM_PLAIN;
      exec(t);
      sw_rd(6'(7 * m), r);
      check("program byte", r, d);
      rd16({1'b0, `CSB_IDX_Z}, v);
      check("pointer after program read", v, b + 16'(m));
    end
    $display("program read test done");
    for (int o = 8; o < 13; o++) begin
      repeat (3) begin
        d = 8'($urandom);
        f = 8'($urandom);
        sw_wr(6'h05, d);
        sw_wr(`CSB_OFS_FLAGS, f);
        exec(mk(csb_pkg::csb_op_t'(o), 5'h05, 5'h05, 3'h0));
        v = shref(csb_pkg::csb_op_t'(o), d, f);
        sw_rd(6'h05, r);
        check("shifted value", r, v[7:0]);
        check("shift flags", flags, v[15:8]);
      end
    end
    $display("shift test done");
    for (int s = 0; s < 8; s++) begin
      a = 6'($urandom_range(0, 31));
      f = 8'($urandom);
      i_csb_mem_model.iomem[a[4:0]] = f;
      t = mk(csb_pkg::OP_IO_BIT_SET, 5'h00, 5'h00, 3'(s));
      t.io_addr = a[4:0];
      exec(t);
      check("bit set", i_csb_mem_model.iomem[a[4:0]], f | 8'h01 << s);
      t.op = csb_pkg::OP_IO_BIT_CLEAR;
      exec(t);
      check("bit clear", i_csb_mem_model.iomem[a[4:0]], f & ~(8'h01 << s));
      sw_wr(`CSB_OFS_FLAGS, f);
      exec(mk(csb_pkg::OP_GENERIC_FLAG_ON, 5'h00, 5'h00, 3'(s)));
      check("flag set", flags, f | 8'h01 << s);
      exec(mk(csb_pkg::OP_GENERIC_FLAG_OFF, 5'h00, 5'h00, 3'(s)));
      check("flag clear", flags, f & ~(8'h01 << s));
      d = 8'($urandom);
      w = 8'($urandom);
      sw_wr(6'h06, d);
      sw_wr(6'h08, w);
      sw_wr(`CSB_OFS_FLAGS, f);
      exec(mk(csb_pkg::OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h06, 3'(s)));
      check("transfer flag", flags, {f[7], d[s], f[5:0]});
      exec(mk(csb_pkg::OP_TRANSFER_FLAG_TO_BIT, 5'h08, 5'h00, 3'(s)));
      sw_rd(6'h08, r);
      w[s] = d[s];
      check("loaded bit", r, w);
      check("flags after bit load", flags, {f[7], d[s], f[5:0]});
    end
    $display("bit and flag test done");
    complete_run();
  end
endmodule : tb_cpu_store_bit_flag_ops
